// *** rtl/dpr_pkg.sv ***
package dpr_pkg;

  // array geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 72;
  localparam int LANES = 8;
  localparam int LANE_W = 9;

  // mailbox words, one per port (index 0 = left, 1 = right)
  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 17'h1FFFE;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 17'h1FFFF;

  // counter and mask reset values
  localparam logic [ADDR_W-1:0] CNT_RST = 17'h00000;
  localparam logic [ADDR_W-1:0] MASK_RST = 17'h1FFFF;

  // register bus map
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_STAT = 4'h4;
  localparam int CTRL_SKEW_BIT = 0;
  localparam logic CTRL_SKEW_RST = 1'b1;
  localparam int STAT_MBOX_LSB = 0;
  localparam int STAT_WRAP_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pins that the host drives into one port
  typedef struct packed {
    logic select_low_n;
    logic select_high;
    logic read_not_write;
    logic out_drive_enable_n;
    logic address_load_n;
    logic count_advance_n;
    logic counter_clear_n;
    logic counter_or_mask_select;
    logic [LANES-1:0] byte_lane_enable_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } dpr_pin_in_t;

  // pins that one port drives back
  typedef struct packed {
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic [ADDR_W-1:0] addr;
    logic addr_oe;
    logic wrap_flag_n;
    logic mailbox_flag_n;
  } dpr_pin_out_t;

  // idle pin sample: deselected, all controls inactive
  localparam dpr_pin_in_t PIN_IN_RST = '{
    dq: '0, addr: '0, byte_lane_enable_n: 8'hFF, select_high: 1'b0, default: 1'b1};

endpackage

// *** rtl/dpr_ram.sv ***
`timescale 1ns/1ps
// What this block does
// - read-to-write with outputs on becomes no-op
// - output state follows previous cycle's controls
// - counter clear and access share one cycle
// - device floats address bus after readback
// - readback drives counter or mask per select
// - cross-port new data: one or two cycles
// - wrap flag always driven, low when an increment reaches maximum
// - increment past wrap repeats from loaded base
// - right mailbox word sets and clears flag
// - flag set by writer edge, cleared by reader
// - select decode, write or read drive
// - output enable pin floats data asynchronously
// - select changes act with one cycle latency
// - load and advance low with select high loads
// - all pins sampled on rising edge except listed
module dpr_ram #(
  parameter int MEM_ADDR_W = dpr_pkg::ADDR_W
) (
  // clock and master clear
  input wire logic mclk,
  input wire logic rst,
  // two ports, index 0 left, index 1 right
  input wire dpr_pkg::dpr_pin_in_t pin_in [2],
  output dpr_pkg::dpr_pin_out_t pin_out [2],
  // register bus, write side
  input wire logic [dpr_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus, read side
  input wire logic [dpr_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int AW = dpr_pkg::ADDR_W;
  localparam int DW = dpr_pkg::DATA_W;
  localparam int LW = dpr_pkg::LANE_W;
  localparam int NL = dpr_pkg::LANES;

  // a shallower array aliases the top words, which still holds the mailboxes
  if (MEM_ADDR_W < 1 || MEM_ADDR_W > AW) begin : g_bad_depth
    $error("dpr_ram: MEM_ADDR_W must lie in 1..ADDR_W");
  end

  logic [DW-1:0] mem [2**MEM_ADDR_W];

  // cross-port views of each port's decoded access
  logic [1:0] wr;
  logic [1:0] rd;
  logic [AW-1:0] acc_addr [2];
  logic [NL-1:0] lanes_on [2];
  logic [DW-1:0] wdata [2];
  logic [1:0] mb_n;
  logic [1:0] wrap_n;
  logic skew_met_r;

  // per-port pipeline, counter and flags
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int PEER = 1 - p;
    localparam logic [AW-1:0] OWN_MBOX = (p == 1) ? dpr_pkg::MBOX_RIGHT_ADDR :
                                                    dpr_pkg::MBOX_LEFT_ADDR;

    dpr_pkg::dpr_pin_in_t in_q_r;
    logic oe_s1_r;
    logic oe_s2_r;
    logic [AW-1:0] cnt_r;
    logic [AW-1:0] cnt_nxt;
    logic [AW-1:0] mask_r;
    logic [AW-1:0] base_r;
    logic wrap_n_r;
    logic wrap_n_nxt;
    logic mb_n_r;
    logic mb_n_nxt;
    logic [DW-1:0] dq_out_r;
    logic dq_oe_r;
    logic [AW-1:0] addr_out_r;
    logic addr_oe_r;

    // decode of the controls captured at the last edge
    logic sel;
    logic clr;
    logic ld;
    logic ldm;
    logic inc;
    logic rb;
    logic nop;
    logic any_lane;
    logic at_max;
    logic hit_max;
    logic collide;
    logic mb_set;
    logic mb_clr;
    logic [AW-1:0] inc_val;
    logic [AW-1:0] rb_val;
    logic [DW-1:0] rd_data;

    assign sel = ~in_q_r.select_low_n & in_q_r.select_high;
    assign clr = ~in_q_r.counter_clear_n;
    assign ld = ~clr & ~in_q_r.address_load_n & ~in_q_r.count_advance_n &
                in_q_r.counter_or_mask_select;
    assign ldm = ~clr & ~in_q_r.address_load_n & ~in_q_r.count_advance_n &
                 ~in_q_r.counter_or_mask_select;
    assign inc = ~clr & in_q_r.address_load_n & ~in_q_r.count_advance_n;
    assign rb = ~clr & ~in_q_r.address_load_n & in_q_r.count_advance_n;

    // clear and load steer this cycle's access, no idle cycle
    assign acc_addr[p] = clr ? dpr_pkg::CNT_RST : (ld ? in_q_r.addr : cnt_r);
    assign lanes_on[p] = ~in_q_r.byte_lane_enable_n;
    assign any_lane = |lanes_on[p];
    assign wdata[p] = in_q_r.dq;

    // outputs still on from a read: the first write slot only turns the bus
    assign nop = dq_oe_r & ~oe_s2_r;
    assign wr[p] = sel & ~in_q_r.read_not_write & ~nop & ~rb;
    assign rd[p] = sel & in_q_r.read_not_write & ~rb;

    // only the bits set in the mask count; at their top the block restarts
    assign inc_val = (cnt_r & ~mask_r) | ((cnt_r + 17'h00001) & mask_r);
    assign at_max = (cnt_r & mask_r) == mask_r;
    assign hit_max = ~at_max & ((inc_val & mask_r) == mask_r);
    assign cnt_nxt = clr ? dpr_pkg::CNT_RST :
                     ld ? in_q_r.addr :
                     inc ? (at_max ? base_r : inc_val) : cnt_r;
    assign wrap_n_nxt = (clr | ld) ? 1'b1 : (inc ? ~hit_max : wrap_n_r);
    assign rb_val = in_q_r.counter_or_mask_select ? cnt_r : mask_r;

    // mailbox: peer's write sets, own read clears, set wins a tie
    assign mb_set = wr[PEER] & (|lanes_on[PEER]) & (acc_addr[PEER] == OWN_MBOX);
    assign mb_clr = rd[p] & any_lane & (acc_addr[p] == OWN_MBOX);
    assign mb_n_nxt = mb_set ? 1'b0 : (mb_clr ? 1'b1 : mb_n_r);

    // same-word peer write: forward it only when the clocks are far enough apart
    assign collide = rd[p] & wr[PEER] & (acc_addr[PEER] == acc_addr[p]) & skew_met_r;
    for (genvar l = 0; l < NL; l++) begin : g_lane
      assign rd_data[l*LW +: LW] = (collide & lanes_on[PEER][l]) ?
        wdata[PEER][l*LW +: LW] :
        mem[acc_addr[p][MEM_ADDR_W-1:0]][l*LW +: LW];
    end

    // pins sampled on the rising edge; output enable also through a two-stage synchroniser
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        in_q_r <= dpr_pkg::PIN_IN_RST;
        oe_s1_r <= 1'b1;
        oe_s2_r <= 1'b1;
      end else begin
        in_q_r <= pin_in[p];
        oe_s1_r <= pin_in[p].out_drive_enable_n;
        oe_s2_r <= oe_s1_r;
      end
    end

    // counter, mask and retransmit base
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cnt_r <= dpr_pkg::CNT_RST;
        mask_r <= dpr_pkg::MASK_RST;
        base_r <= dpr_pkg::CNT_RST;
        wrap_n_r <= 1'b1;
        mb_n_r <= 1'b1;
      end else begin
        cnt_r <= cnt_nxt;
        mask_r <= ldm ? in_q_r.addr : mask_r;
        base_r <= clr ? dpr_pkg::CNT_RST : (ld ? in_q_r.addr : base_r);
        wrap_n_r <= wrap_n_nxt;
        mb_n_r <= mb_n_nxt;
      end
    end

    // output stage: state set by controls of the cycle before
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        dq_out_r <= '0;
        dq_oe_r <= 1'b0;
        addr_out_r <= '0;
        addr_oe_r <= 1'b0;
      end else begin
        dq_out_r <= rd_data;
        dq_oe_r <= rd[p];
        addr_out_r <= rb_val;
        addr_oe_r <= rb;
      end
    end

    assign mb_n[p] = mb_n_r;
    assign wrap_n[p] = wrap_n_r;

    // the raw enable pin gates the driver with no clock in the path
    assign pin_out[p].dq = dq_out_r;
    assign pin_out[p].dq_oe = dq_oe_r & ~pin_in[p].out_drive_enable_n;
    assign pin_out[p].addr = addr_out_r;
    assign pin_out[p].addr_oe = addr_oe_r;
    assign pin_out[p].wrap_flag_n = wrap_n_r;
    assign pin_out[p].mailbox_flag_n = mb_n_r;
  end

  // array write by lane; right port lands last on a same-word clash
  always_ff @(posedge mclk) begin
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < NL; l++) begin
        if (wr[p] && lanes_on[p][l]) begin
          mem[acc_addr[p][MEM_ADDR_W-1:0]][l*LW +: LW] <= wdata[p][l*LW +: LW];
        end
      end
    end
  end

  // register bus write side: address and data taken in either order
  logic awready_r;
  logic wready_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [dpr_pkg::AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic w_lane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic wr_ctrl;

  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take = s_axi_wvalid & wready_r;
  assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_ctrl = aw_addr_r == dpr_pkg::OFS_CTRL;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_lane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= dpr_pkg::RESP_OKAY;
      skew_met_r <= dpr_pkg::CTRL_SKEW_RST;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ctrl ? dpr_pkg::RESP_OKAY : dpr_pkg::RESP_SLVERR;
        if (wr_ctrl && w_lane0_r) begin
          skew_met_r <= w_data_r[dpr_pkg::CTRL_SKEW_BIT];
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // register bus read side; status shows live flag levels
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic ar_take;
  logic rd_ctrl;
  logic rd_stat;
  logic [31:0] rd_word;

  assign ar_take = s_axi_arvalid & arready_r;
  assign rd_ctrl = s_axi_araddr == dpr_pkg::OFS_CTRL;
  assign rd_stat = s_axi_araddr == dpr_pkg::OFS_STAT;
  assign rd_word = rd_ctrl ? {31'h00000000, skew_met_r} :
                   rd_stat ? {28'h0000000, wrap_n, mb_n} : 32'h00000000;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= dpr_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (rd_ctrl | rd_stat) ? dpr_pkg::RESP_OKAY : dpr_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule // dpr_ram

// *** verif/dpr_ram_checker.sv ***
`timescale 1ns/1ps
// pin-level checks, left port plus right mailbox flag
module dpr_ram_checker (
  // clock and clear
  input wire logic mclk,
  input wire logic rst,
  // both ports
  input wire dpr_pkg::dpr_pin_in_t pin_in [2],
  input wire dpr_pkg::dpr_pin_out_t pin_out [2]
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  dpr_pkg::dpr_pin_in_t l, r;
  logic sel, rd, rdany, rb, ld, mwr, mrd;
  // decode of the sampled pins; load needs clear off
  assign l = pin_in[0];
  assign r = pin_in[1];
  assign sel = !l.select_low_n && l.select_high;
  // any read; a write right after one may be a turnaround no-op
  assign rdany = sel && l.read_not_write;
  assign rd = sel && l.read_not_write && !l.count_advance_n;
  assign rb = l.counter_clear_n && !l.address_load_n && l.count_advance_n;
  assign ld = {l.counter_clear_n, l.address_load_n, l.count_advance_n,
    l.counter_or_mask_select} == 4'h9;
  assign mwr = sel && !l.read_not_write && ld && l.addr == dpr_pkg::MBOX_RIGHT_ADDR
    && l.byte_lane_enable_n != 8'hFF;
  // left idle so a set cannot win over this clear
  assign mrd = !r.select_low_n && r.select_high && r.read_not_write && !sel
    && r.addr == dpr_pkg::MBOX_RIGHT_ADDR && !r.address_load_n && !r.count_advance_n
    && r.counter_clear_n && r.counter_or_mask_select
    && r.byte_lane_enable_n != 8'hFF;
  oe_async_a: assert property (l.out_drive_enable_n |-> !pin_out[0].dq_oe)
    else $error("data driven while output enable off");
  desel_float_a: assert property (!sel |-> ##2 !pin_out[0].dq_oe)
    else $error("data driven after deselect");
  read_drive_a: assert property (rd
    |-> ##2 (l.out_drive_enable_n || pin_out[0].dq_oe))
    else $error("read data not driven");
  rb_drive_a: assert property (rb |-> ##2 pin_out[0].addr_oe)
    else $error("readback not driven");
  rb_release_a: assert property (!rb |-> ##2 !pin_out[0].addr_oe)
    else $error("address lines not released");
  wrap_high_a: assert property ((ld || !l.counter_clear_n)
    |-> ##[1:2] pin_out[0].wrap_flag_n)
    else $error("wrap flag low after load or clear");
  mbox_set_a: assert property (mwr && !$past(rdany)
    |-> ##[1:2] !pin_out[1].mailbox_flag_n)
    else $error("mailbox flag not set");
  mbox_clr_a: assert property (mrd ##1 !mwr |-> ##[0:1] pin_out[1].mailbox_flag_n)
    else $error("mailbox flag not cleared");
endmodule // dpr_ram_checker

bind dpr_ram dpr_ram_checker u_chk (.mclk(mclk), .rst(rst), .pin_in(pin_in),
  .pin_out(pin_out));

// *** verif/dpr_host.sv ***
`timescale 1ns/1ps
// host on one ram port, changes pins just after an edge
module dpr_host (
  // clock
  input wire logic mclk,
  // pins toward the port
  output dpr_pkg::dpr_pin_in_t pin
);
  initial pin = dpr_pkg::PIN_IN_RST;
  // c = {sel, rnw, oe_n, load_n, adv_n, clr_n, cms}
  task put(input logic [6:0] c, input logic [16:0] a, input logic [71:0] d);
    @(posedge mclk);
    pin.select_low_n <= !c[6];
    pin.select_high <= c[6];
    pin.read_not_write <= c[5];
    pin.out_drive_enable_n <= c[4];
    pin.address_load_n <= c[3];
    pin.count_advance_n <= c[2];
    pin.counter_clear_n <= c[1];
    pin.counter_or_mask_select <= c[0];
    pin.byte_lane_enable_n <= 8'h00;
    // undriven lines toggle so stale values never pass for held ones
    pin.addr <= (c[3:2] == 2'h0) ? a : ~pin.addr;
    pin.dq <= c[5] ? ~pin.dq : d;
  endtask
endmodule // dpr_host

// *** verif/dual_port_sync_ram_port_tb_top.sv ***
`timescale 1ns/1ps
// bench: two hosts on the ports, register bus driven here
module dual_port_sync_ram_port_tb_top;
  localparam logic [6:0] IDL = 7'h2F, WR = 7'h43, RD = 7'h63, INC = 7'h6B;
  localparam logic [6:0] WCL = 7'h4D, RBC = 7'h67, RBM = 7'h66, ROF = 7'h73, LDM = 7'h22;
  localparam logic [71:0] D1 = 72'h12_3456_789A_BCDE_F012, D2 = 72'hF0_0F0F_F00F_1234_5678;
  localparam logic [71:0] D3 = 72'h55_AAAA_5555_AAAA_5555;
  logic mclk, rst;
  dpr_pkg::dpr_pin_in_t pi [2];
  dpr_pkg::dpr_pin_out_t po [2];
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int miscompares, cmp_count, cyc;

  dpr_host u_hl (.mclk(mclk), .pin(pi[0]));
  dpr_host u_hr (.mclk(mclk), .pin(pi[1]));
  dpr_ram u_dut (.mclk(mclk), .rst(rst), .pin_in(pi), .pin_out(po),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // clock, and a hang limit well past the whole run
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [71:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic op(input bit r, input logic [6:0] c, input logic [16:0] a = 0,
      input logic [71:0] d = 0);
    if (r) u_hr.put(c, a, d);
    else u_hl.put(c, a, d);
  endtask
  task nx;
    @(posedge mclk);
    #1;
  endtask
  task automatic rdchk(input bit r, input logic [16:0] a, input logic [71:0] e);
    op(r, RD, a);
    op(r, IDL);
    nx;
    chk("dq_oe", po[r].dq_oe, 1'b1);
    chk("dq", po[r].dq, e);
  endtask
  // aw and w offered together, each dropped once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, e);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, d);
    chk("rresp", rresp, e);
  endtask

  task t_basic;
    op(0, WR, 17'h00010, D1);
    op(0, IDL);
    rdchk(1, 17'h00010, D1);
    // enable kept off through the cycle in which the read would drive
    op(1, ROF, 17'h00010);
    op(1, ROF, 17'h00010);
    nx;
    chk("dq_oe", po[1].dq_oe, 1'b0);
    $display("basic done");
  endtask
  task t_noop;
    op(1, RD, 17'h00010);
    op(1, RD, 17'h00010);
    op(1, WR, 17'h00010, D3);
    op(1, IDL);
    rdchk(1, 17'h00010, D1);
    op(1, IDL);
    op(1, WR, 17'h00010, D1);
    $display("noop done");
  endtask
  task t_clr_rb;
    op(0, WCL, 17'h00000, D2);
    op(0, IDL);
    rdchk(0, 17'h00000, D2);
    op(0, RD, 17'h00123);
    op(0, RBC);
    op(0, IDL);
    nx;
    chk("addr_oe", po[0].addr_oe, 1'b1);
    chk("cnt", po[0].addr, 17'h00123);
    op(0, RBM);
    op(0, IDL);
    nx;
    chk("mask", po[0].addr, dpr_pkg::MASK_RST);
    nx;
    chk("addr_oe", po[0].addr_oe, 1'b0);
    // load a narrow mask, read it back, then restore the full mask for the wrap test
    op(0, LDM, 17'h000FF);
    op(0, RBM);
    op(0, IDL);
    nx;
    chk("mask", po[0].addr, 17'h000FF);
    op(0, LDM, dpr_pkg::MASK_RST);
    $display("clear readback done");
  endtask
  task t_wrap;
    op(0, RD, 17'h1FFFE);
    op(0, INC);
    op(0, IDL);
    nx;
    chk("wrap", po[0].wrap_flag_n, 1'b0);
    op(0, INC);
    op(0, IDL);
    nx;
    chk("wrap", po[0].wrap_flag_n, 1'b1);
    op(0, RBC);
    op(0, IDL);
    nx;
    chk("base", po[0].addr, 17'h1FFFE);
    $display("wrap done");
  endtask
  task t_mbox;
    op(0, WR, dpr_pkg::MBOX_RIGHT_ADDR, D2);
    op(0, IDL);
    nx;
    chk("mbox", po[1].mailbox_flag_n, 1'b0);
    axr(dpr_pkg::OFS_STAT, 32'h0000000D, dpr_pkg::RESP_OKAY);
    rdchk(1, dpr_pkg::MBOX_RIGHT_ADDR, D2);
    chk("mbox", po[1].mailbox_flag_n, 1'b1);
    $display("mailbox done");
  endtask
  // only one side writes the shared word
  task t_cross;
    axr(dpr_pkg::OFS_CTRL, 32'(dpr_pkg::CTRL_SKEW_RST), dpr_pkg::RESP_OKAY);
    axw(dpr_pkg::OFS_STAT, 32'h0, dpr_pkg::RESP_SLVERR);
    axr(4'h8, 32'h0, dpr_pkg::RESP_SLVERR);
    fork
      op(0, WR, 17'h00040, D3);
      op(1, RD, 17'h00040);
    join
    fork
      op(0, IDL);
      op(1, IDL);
    join
    nx;
    chk("cross", po[1].dq, D3);
    axw(dpr_pkg::OFS_CTRL, 32'h0, dpr_pkg::RESP_OKAY);
    fork
      op(0, WR, 17'h00040, D1);
      op(1, RD, 17'h00040);
    join
    op(0, IDL);
    rdchk(1, 17'h00040, D1);
    $display("cross and registers done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_cross();
    t_basic();
    t_noop();
    t_clr_rb();
    t_wrap();
    t_mbox();
    final_report();
  end
endmodule // dual_port_sync_ram_port_tb_top
